// File: mis_flag_cell.sv
`timescale 1ns/100ps
module mis_flag_cell (
    input  wire logic i_ref_clk,
    input  wire logic i_resetn,
    input  wire logic i_set,
    input  wire logic i_clr,
    output logic      o_flag
);
    logic flag_d;
    logic flag_q;

    // set wins over a clear in the same cycle
    always_comb begin
        flag_d = i_set | (flag_q & ~i_clr);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign o_flag = flag_q;
endmodule

// File: mis_host.sv
`timescale 1ns/100ps
module mis_host (
    input  wire logic        i_ref_clk,
    output logic [7:0]       o_awaddr,
    output logic             o_awvalid,
    input  wire logic        i_awready,
    output logic [31:0]      o_wdata,
    output logic [3:0]       o_wstrb,
    output logic             o_wvalid,
    input  wire logic        i_wready,
    input  wire logic        i_bvalid,
    output logic             o_bready,
    output logic [7:0]       o_araddr,
    output logic             o_arvalid,
    input  wire logic        i_arready,
    input  wire logic        i_rvalid,
    output logic             o_rready
);
    // response readies stay high, so back-to-back calls never retoggle them
    initial begin
        {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_araddr, o_arvalid} <= '0;
        o_bready <= 1'b1;
        o_rready <= 1'b1;
    end
    // call right after a rising edge; readies seen at the falling edge hold to the next rise
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ad;
        logic wd;
        logic ra;
        logic rw;
        ad = 1'b0;
        wd = 1'b0;
        o_awaddr <= a;
        o_wdata <= d;
        o_wstrb <= s;
        o_awvalid <= 1'b1;
        o_wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge i_ref_clk);
            ra = i_awready && !ad;
            rw = i_wready && !wd;
            @(posedge i_ref_clk);
            if (ra) begin
                ad = 1'b1;
                o_awvalid <= 1'b0;
                o_awaddr <= ~a;
            end
            if (rw) begin
                wd = 1'b1;
                o_wvalid <= 1'b0;
                o_wdata <= ~d;
            end
        end
        ra = 1'b0;
        while (!ra) begin
            @(negedge i_ref_clk);
            ra = i_bvalid;
            @(posedge i_ref_clk);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        o_araddr <= a;
        o_arvalid <= 1'b1;
        while (!ok) begin
            @(negedge i_ref_clk);
            ok = i_arready;
            @(posedge i_ref_clk);
        end
        o_arvalid <= 1'b0;
        o_araddr <= ~a;
        ok = 1'b0;
        while (!ok) begin
            @(negedge i_ref_clk);
            ok = i_rvalid;
            @(posedge i_ref_clk);
        end
    endtask
endmodule

// File: mis_pkg.sv
package mis_pkg;

    localparam int unsigned ADDR_W = 8;

    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_INT_ENABLE     = 8'h06;
    localparam logic [7:0] IDX_PENDING_STATUS = 8'h14;
    localparam logic [7:0] IDX_COMM_CONTROL   = 8'h31;

    localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE     = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_PENDING_STATUS = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_COMM_CONTROL   = 8'hc4;

    localparam int unsigned SEL_CLR_POS = 0;

    localparam logic [7:0] PENDING_RESET   = 8'h00;
    localparam logic [7:0] ENABLE_RESET    = 8'h00;
    localparam logic [7:0] FLAG_VALID_MASK = 8'hbf;
    localparam logic [7:0] CLEAR_ALL       = 8'hff;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic sample_acquired_pending;
        logic reserved;
        logic fifo;
        logic steep_tilt;
        logic shake;
        logic general_motion_event_pending;
        logic flip;
        logic tilt;
    } mis_flags_t;

    typedef enum logic [0:0] {
        MIS_CH_IDLE = 1'b0,
        MIS_CH_RESP = 1'b1
    } mis_ch_state_t;

endpackage

// File: mis_top.sv
`timescale 1ns/100ps
module mis_top (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_resetn,
    input  wire mis_pkg::mis_flags_t        i_events,
    input  wire logic [mis_pkg::ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic                       i_s_axi_awvalid,
    output logic                            o_s_axi_awready,
    input  wire logic [31:0]                i_s_axi_wdata,
    input  wire logic [3:0]                 i_s_axi_wstrb,
    input  wire logic                       i_s_axi_wvalid,
    output logic                            o_s_axi_wready,
    output logic [1:0]                      o_s_axi_bresp,
    output logic                            o_s_axi_bvalid,
    input  wire logic                       i_s_axi_bready,
    input  wire logic [mis_pkg::ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic                       i_s_axi_arvalid,
    output logic                            o_s_axi_arready,
    output logic [31:0]                     o_s_axi_rdata,
    output logic [1:0]                      o_s_axi_rresp,
    output logic                            o_s_axi_rvalid,
    input  wire logic                       i_s_axi_rready,
    output logic                            o_irq
);
    mis_pkg::mis_ch_state_t     wr_state_d, wr_state_q;
    mis_pkg::mis_ch_state_t     rd_state_d, rd_state_q;
    logic                       aw_have_d, aw_have_q;
    logic                       w_have_d, w_have_q;
    logic [mis_pkg::ADDR_W-1:0] awaddr_d, awaddr_q;
    logic [31:0]                wdata_d, wdata_q;
    logic [3:0]                 wstrb_d, wstrb_q;
    logic [1:0]                 bresp_d, bresp_q;
    logic                       awready_d, awready_q;
    logic                       wready_d, wready_q;
    logic                       arready_d, arready_q;
    logic [31:0]                rdata_d, rdata_q;
    logic [1:0]                 rresp_d, rresp_q;
    logic [7:0]                 enable_d, enable_q;
    logic                       sel_clr_d, sel_clr_q;
    logic                       irq_d, irq_q;
    logic                       wr_fire;
    logic                       lane0;
    logic                       st_wr;
    logic [7:0]                 w_mask;
    logic [7:0]                 set_v;
    logic [7:0]                 clr_v;
    logic [7:0]                 pend_q;
    logic [7:0]                 pend_d;

    assign wr_fire = (wr_state_q == mis_pkg::MIS_CH_IDLE) && aw_have_q && w_have_q;
    assign lane0   = wstrb_q[0];
    assign st_wr   = wr_fire && lane0 && (awaddr_q == mis_pkg::ADDR_PENDING_STATUS);
    assign w_mask  = sel_clr_q ? wdata_q[7:0] : mis_pkg::CLEAR_ALL;
    assign set_v   = i_events & enable_q & mis_pkg::FLAG_VALID_MASK;
    assign clr_v   = st_wr ? w_mask : 8'h00;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            mis_flag_cell u_cell (
                .i_ref_clk (i_ref_clk),
                .i_resetn  (i_resetn),
                .i_set     (set_v[gi]),
                .i_clr     (clr_v[gi]),
                .o_flag    (pend_q[gi])
            );
        end
    endgenerate

    assign pend_d = set_v | (pend_q & ~clr_v);

    // write channel and register updates
    always_comb begin
        wr_state_d = wr_state_q;
        aw_have_d  = aw_have_q;
        w_have_d   = w_have_q;
        awaddr_d   = awaddr_q;
        wdata_d    = wdata_q;
        wstrb_d    = wstrb_q;
        bresp_d    = bresp_q;
        enable_d   = enable_q;
        sel_clr_d  = sel_clr_q;
        if (awready_q && i_s_axi_awvalid) begin
            aw_have_d = 1'b1;
            awaddr_d  = i_s_axi_awaddr;
        end
        if (wready_q && i_s_axi_wvalid) begin
            w_have_d = 1'b1;
            wdata_d  = i_s_axi_wdata;
            wstrb_d  = i_s_axi_wstrb;
        end
        case (wr_state_q)
            mis_pkg::MIS_CH_IDLE: begin
                if (wr_fire) begin
                    wr_state_d = mis_pkg::MIS_CH_RESP;
                    aw_have_d  = 1'b0;
                    w_have_d   = 1'b0;
                    bresp_d    = mis_pkg::RESP_OKAY;
                    case (awaddr_q)
                        mis_pkg::ADDR_INT_ENABLE: begin
                            if (lane0) begin
                                enable_d = wdata_q[7:0] & mis_pkg::FLAG_VALID_MASK;
                            end
                        end
                        mis_pkg::ADDR_COMM_CONTROL: begin
                            if (lane0) begin
                                sel_clr_d = wdata_q[mis_pkg::SEL_CLR_POS];
                            end
                        end
                        mis_pkg::ADDR_PENDING_STATUS: begin
                            bresp_d = mis_pkg::RESP_OKAY;
                        end
                        default: begin
                            bresp_d = mis_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            mis_pkg::MIS_CH_RESP: begin
                if (i_s_axi_bready) begin
                    wr_state_d = mis_pkg::MIS_CH_IDLE;
                end
            end
            default: begin
                wr_state_d = mis_pkg::MIS_CH_IDLE;
            end
        endcase
        awready_d = (wr_state_d == mis_pkg::MIS_CH_IDLE) && !aw_have_d;
        wready_d  = (wr_state_d == mis_pkg::MIS_CH_IDLE) && !w_have_d;
        irq_d     = |pend_d;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            wr_state_q <= mis_pkg::MIS_CH_IDLE;
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            awaddr_q   <= '0;
            wdata_q    <= 32'h0000_0000;
            wstrb_q    <= 4'h0;
            bresp_q    <= mis_pkg::RESP_OKAY;
            awready_q  <= 1'b0;
            wready_q   <= 1'b0;
            enable_q   <= mis_pkg::ENABLE_RESET;
            sel_clr_q  <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            wr_state_q <= wr_state_d;
            aw_have_q  <= aw_have_d;
            w_have_q   <= w_have_d;
            awaddr_q   <= awaddr_d;
            wdata_q    <= wdata_d;
            wstrb_q    <= wstrb_d;
            bresp_q    <= bresp_d;
            awready_q  <= awready_d;
            wready_q   <= wready_d;
            enable_q   <= enable_d;
            sel_clr_q  <= sel_clr_d;
            irq_q      <= irq_d;
        end
    end

    // read channel
    always_comb begin
        rd_state_d = rd_state_q;
        rdata_d    = rdata_q;
        rresp_d    = rresp_q;
        case (rd_state_q)
            mis_pkg::MIS_CH_IDLE: begin
                if (arready_q && i_s_axi_arvalid) begin
                    rd_state_d = mis_pkg::MIS_CH_RESP;
                    rresp_d    = mis_pkg::RESP_OKAY;
                    case (i_s_axi_araddr)
                        mis_pkg::ADDR_PENDING_STATUS: rdata_d = {24'h00_0000, pend_q};
                        mis_pkg::ADDR_INT_ENABLE: rdata_d = {24'h00_0000, enable_q};
                        mis_pkg::ADDR_COMM_CONTROL: rdata_d = {31'h0000_0000, sel_clr_q};
                        default: begin
                            rdata_d = 32'h0000_0000;
                            rresp_d = mis_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            mis_pkg::MIS_CH_RESP: begin
                if (i_s_axi_rready) begin
                    rd_state_d = mis_pkg::MIS_CH_IDLE;
                end
            end
            default: begin
                rd_state_d = mis_pkg::MIS_CH_IDLE;
            end
        endcase
        arready_d = (rd_state_d == mis_pkg::MIS_CH_IDLE);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            rd_state_q <= mis_pkg::MIS_CH_IDLE;
            rdata_q    <= 32'h0000_0000;
            rresp_q    <= mis_pkg::RESP_OKAY;
            arready_q  <= 1'b0;
        end else begin
            rd_state_q <= rd_state_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
            arready_q  <= arready_d;
        end
    end

    assign o_s_axi_awready = awready_q;
    assign o_s_axi_wready  = wready_q;
    assign o_s_axi_bvalid  = (wr_state_q == mis_pkg::MIS_CH_RESP);
    assign o_s_axi_bresp   = bresp_q;
    assign o_s_axi_arready = arready_q;
    assign o_s_axi_rvalid  = (rd_state_q == mis_pkg::MIS_CH_RESP);
    assign o_s_axi_rdata   = rdata_q;
    assign o_s_axi_rresp   = rresp_q;
    assign o_irq           = irq_q;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_both_held;
        aw_have_q && w_have_q && (wr_state_q == mis_pkg::MIS_CH_IDLE);
    endsequence
    sequence s_resp_up;
        o_s_axi_bvalid && (o_s_axi_awready == 1'b0);
    endsequence

    a_pend_needs_enable: assert property (((pend_q & ~$past(pend_q) & ~$past(set_v)) == 8'h00))
        else $error("flag set without enabled source");
    a_default_clear_all: assert property (st_wr && !sel_clr_q |=> ((pend_q & ~$past(set_v)) == 8'h00))
        else $error("default write left a flag set");
    a_mask_clear_sel: assert property (st_wr && sel_clr_q |=> ((pend_q & $past(w_mask) & ~$past(set_v)) == 8'h00))
        else $error("masked flag not cleared");
    a_mask_keep_rest: assert property (st_wr && sel_clr_q |=> (($past(pend_q) & ~$past(w_mask) & ~pend_q) == 8'h00))
        else $error("unmasked flag was cleared");
    a_resv_bit_zero: assert property (pend_q[6] == 1'b0)
        else $error("reserved flag set");
    a_read_status: assert property (arready_q && i_s_axi_arvalid && (i_s_axi_araddr == mis_pkg::ADDR_PENDING_STATUS)
        |=> o_s_axi_rvalid && (o_s_axi_rdata == {24'h00_0000, $past(pend_q)}))
        else $error("status read returned wrong flags");
    a_reset_flags_zero: assert property (@(posedge i_ref_clk) disable iff (1'b0) $past(!i_resetn) |-> (pend_q == 8'h00))
        else $error("flags not zero after reset");
    a_write_resp: assert property (s_both_held |=> s_resp_up)
        else $error("write response missing");
    a_bvalid_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("bvalid dropped early");
    a_irq_level: assert property (o_irq == (pend_q != 8'h00))
        else $error("irq does not follow flags");
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic                i_ref_clk;
    logic                i_resetn;
    mis_pkg::mis_flags_t ev;
    logic [7:0]          awaddr, araddr, flg, en, m;
    logic                awvalid, awready, wvalid, wready, bvalid, bready;
    logic                arvalid, arready, rvalid, rready, irq, mode;
    logic [31:0]         wdata, rdata;
    logic [3:0]          wstrb, s;
    logic [1:0]          bresp, rresp;
    logic [33:0]         rq[$];
    logic [1:0]          bq[$];
    int                  mismatches, checks_done, cyc;

    mis_top i_mis_top (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_events(ev),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready), .o_irq(irq));
    mis_host i_mis_host (.i_ref_clk(i_ref_clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
        .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready),
        .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid),
        .i_arready(arready), .i_rvalid(rvalid), .o_rready(rready));

    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input string n, input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
        rq.push_back({r, d});
        i_mis_host.rd(a);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] r);
        bq.push_back(r);
        i_mis_host.wr(a, d, st);
    endtask
    task automatic chk_irq;
        @(negedge i_ref_clk);
        check("irq", {33'h0, irq}, {33'h0, |flg});
        @(posedge i_ref_clk);
    endtask
    task automatic finish_test;
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // response watcher: oldest note against each answer
    always @(posedge i_ref_clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) check("read", {rresp, rdata}, rq.size() ? rq.pop_front() : '1);
        if (bvalid === 1'b1 && bready === 1'b1) check("bresp", {32'h0, bresp}, bq.size() ? bq.pop_front() : '1);
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        i_resetn = 1'b0;
        ev = '0;
        flg = 8'h00;
        void'($urandom(32'hc95ecf7c));
        repeat (3) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(posedge i_ref_clk);
        rd(mis_pkg::ADDR_PENDING_STATUS, mis_pkg::RESP_OKAY, {24'h0, mis_pkg::PENDING_RESET});
        rd(mis_pkg::ADDR_INT_ENABLE, mis_pkg::RESP_OKAY, {24'h0, mis_pkg::ENABLE_RESET});
        rd(mis_pkg::ADDR_COMM_CONTROL, mis_pkg::RESP_OKAY, 32'h0);
        rd(8'h54, mis_pkg::RESP_SLVERR, 32'h0);
        wr(8'h54, 32'hff, 4'hf, mis_pkg::RESP_SLVERR);
        chk_irq();
        repeat (30) begin
            mode = 1'($urandom);
            en = 8'($urandom);
            m = 8'($urandom);
            s = ($urandom % 4 == 0) ? 4'he : 4'hf;
            wr(mis_pkg::ADDR_COMM_CONTROL, {31'h0, mode}, 4'h1, mis_pkg::RESP_OKAY);
            wr(mis_pkg::ADDR_INT_ENABLE, {24'h0, en}, 4'h1, mis_pkg::RESP_OKAY);
            rd(mis_pkg::ADDR_COMM_CONTROL, mis_pkg::RESP_OKAY, {31'h0, mode});
            rd(mis_pkg::ADDR_INT_ENABLE, mis_pkg::RESP_OKAY, {24'h0, en & mis_pkg::FLAG_VALID_MASK});
            ev <= mis_pkg::mis_flags_t'(8'($urandom));
            @(posedge i_ref_clk);
            flg = flg | (ev & en & mis_pkg::FLAG_VALID_MASK);
            ev <= '0;
            repeat (2) @(posedge i_ref_clk);
            rd(mis_pkg::ADDR_PENDING_STATUS, mis_pkg::RESP_OKAY, {24'h0, flg});
            chk_irq();
            wr(mis_pkg::ADDR_PENDING_STATUS, {24'h0, m}, s, mis_pkg::RESP_OKAY);
            // write without the low lane leaves the flags alone
            if (s[0]) flg = mode ? (flg & ~m) : 8'h00;
            rd(mis_pkg::ADDR_PENDING_STATUS, mis_pkg::RESP_OKAY, {24'h0, flg});
            chk_irq();
        end
        wr(mis_pkg::ADDR_INT_ENABLE, 32'h0000_00ff, 4'h1, mis_pkg::RESP_OKAY);
        ev <= '1;
        @(posedge i_ref_clk);
        flg = mis_pkg::FLAG_VALID_MASK;
        ev <= '0;
        repeat (2) @(posedge i_ref_clk);
        rd(mis_pkg::ADDR_PENDING_STATUS, mis_pkg::RESP_OKAY, {24'h0, flg});
        chk_irq();
        // reset in mid-run with every flag but the reserved one set
        i_resetn <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(posedge i_ref_clk);
        flg = mis_pkg::PENDING_RESET;
        rd(mis_pkg::ADDR_PENDING_STATUS, mis_pkg::RESP_OKAY, {24'h0, mis_pkg::PENDING_RESET});
        rd(mis_pkg::ADDR_INT_ENABLE, mis_pkg::RESP_OKAY, {24'h0, mis_pkg::ENABLE_RESET});
        rd(mis_pkg::ADDR_COMM_CONTROL, mis_pkg::RESP_OKAY, 32'h0);
        chk_irq();
        repeat (2) @(posedge i_ref_clk);
        check("queues", 34'(rq.size() + bq.size()), 34'h0);
        finish_test();
    end
endmodule
